// ===== rtl/acc_pkg.sv
// Purpose: shared constants and helpers for the audio clock/companding control block
// Assumes: 9-bit control registers, word index times four is the byte address
// Notes: reset values follow the register defaults
package acc_pkg;
    localparam int REG_W = 9;
    localparam int WORD_W = 16;
    localparam logic [5:0] IDX_PWR1 = 6'h01;
    localparam logic [5:0] IDX_AFMT = 6'h04;
    localparam logic [5:0] IDX_CMP = 6'h05;
    localparam logic [5:0] IDX_CLK = 6'h06;
    localparam logic [5:0] IDX_ADD = 6'h07;
    localparam logic [5:0] IDX_PIN = 6'h08;
    localparam logic [5:0] IDX_PLL_INTEGER_RATIO = 6'h24;
    localparam logic [5:0] IDX_FRH = 6'h25;
    localparam logic [5:0] IDX_FRM = 6'h26;
    localparam logic [5:0] IDX_FRL = 6'h27;
    localparam logic [5:0] IDX_STAT = 6'h28;
    localparam logic [8:0] RST_PWR1 = 9'h000;
    localparam logic [8:0] RST_AFMT = 9'h050;
    localparam logic [8:0] RST_CMP = 9'h000;
    localparam logic [8:0] RST_CLK = 9'h140;
    localparam logic [8:0] RST_ADD = 9'h000;
    localparam logic [8:0] RST_PIN = 9'h000;
    localparam logic [8:0] RST_PLL_INTEGER_RATIO = 9'h008;
    localparam logic [8:0] RST_FRH = 9'h00C;
    localparam logic [8:0] RST_FRM = 9'h093;
    localparam logic [8:0] RST_FRL = 9'h0E9;
    // field positions
    localparam int F_VMID_LO = 0;
    localparam int F_PLL_ENABLE = 5;
    localparam int F_BCP = 8;
    localparam int F_LOOP = 0;
    localparam int F_ADCC_LO = 1;
    localparam int F_DACC_LO = 3;
    localparam int F_MS = 0;
    localparam int F_BDIV_LO = 2;
    localparam int F_MDIV_LO = 5;
    localparam int F_CLOCK_SOURCE_SELECT = 8;
    localparam int F_DBCLK = 0;
    localparam int F_SR_LO = 1;
    localparam int F_PSC = 4;
    localparam int F_PIN_LO = 0;
    localparam int FRAME_SYSCLKS = 256;
    localparam logic [7:0] MU_FLIP = 8'hFF;
    localparam logic [7:0] A_FLIP = 8'h55;
    localparam logic [12:0] MU_BIAS = 13'h0021;
    localparam logic [15:0] MU_DBIAS = 16'h0084;
    localparam logic [15:0] A_DBIAS = 16'h0108;
    typedef enum logic [1:0] {ACC_CMP_OFF, ACC_CMP_RSV, ACC_CMP_MU, ACC_CMP_A} acc_cmp_t;
    typedef enum logic [2:0] {ACC_PIN_CS, ACC_PIN_JACK, ACC_PIN_TEMP, ACC_PIN_AMUTE,
        ACC_PIN_PLLCLK, ACC_PIN_LOCK, ACC_PIN_RSV6, ACC_PIN_RSV7} acc_pin_t;

    // source half-periods per internal clock: 2,3,4,6,8,12,16,24
    function automatic logic [4:0] acc_scale_halves(input logic [2:0] code);
        logic [4:0] t [8];
        t = '{5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0C, 5'h10, 5'h18};
        return t[code];
    endfunction

    // internal-clock multiple of the 48 kHz frame, in halves
    function automatic logic [3:0] acc_rate_halves(input logic [2:0] code);
        logic [3:0] t [8];
        t = '{4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'hC, 4'h2, 4'h2};
        return t[code];
    endfunction
endpackage

// ===== rtl/acc_core_if.sv
// Purpose: carrier between the control top and its clock and compander units
// Assumes: all signals on sys_clk
// Notes: none
`timescale 1ns/1ns
interface acc_core_if;
    logic clk_src_sel;
    logic [2:0] scaler;
    logic [2:0] bdiv;
    logic [2:0] rate;
    logic bclk_m;
    logic frame_m;
    logic int_tick;
    logic [15:0] adc_lin;
    logic [1:0] adc_mode;
    logic [7:0] adc_code;
    logic [1:0] dac_mode;
    logic [7:0] dac_code;
    logic [15:0] dac_lin;
    modport ctl(output clk_src_sel, scaler, bdiv, rate, adc_lin, adc_mode, dac_mode, dac_code,
        input bclk_m, frame_m, int_tick, adc_code, dac_lin);
    modport gen(input clk_src_sel, scaler, bdiv, rate, output bclk_m, frame_m, int_tick);
    modport cmp(input adc_lin, adc_mode, dac_mode, dac_code, output adc_code, dac_lin);
endinterface

// ===== rtl/acc_clkgen.sv
// Purpose: internal clock scaler and master bit/frame clock generator
// Assumes: clock sources are sampled levels far slower than sys_clk
// Notes: counts are in source half-periods so that divide by 1.5 is exact
`timescale 1ns/1ns
module acc_clkgen
    import acc_pkg::*;
(
    input wire logic sys_clk, // system clock
    input wire logic rst, // async reset
    input wire logic mclk_i, // external master clock level
    input wire logic pll_clk_i, // pll output level
    acc_core_if.gen g // controls and clocks
);
    logic src_q;
    logic src_d;
    logic edge_s;
    logic [15:0] fcnt_q;
    logic [15:0] bcnt_q;
    logic [4:0] icnt_q;
    logic [15:0] flen;
    logic [15:0] bhalf;
    logic [4:0] shalf;

    assign src_d = g.clk_src_sel ? pll_clk_i : mclk_i;
    assign edge_s = src_d ^ src_q;
    assign shalf = acc_scale_halves(g.scaler);
    assign flen = 16'(shalf * acc_rate_halves(g.rate) * (FRAME_SYSCLKS / 2));
    // reserved divider codes clamp to the largest ratio
    assign bhalf = (g.bdiv > 3'h5) ? 16'(shalf) << 4 : (16'(shalf) << g.bdiv) >> 1;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            src_q <= 1'b0;
        else
            src_q <= src_d;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            icnt_q <= 5'h00;
            g.int_tick <= 1'b0;
        end
        else
        begin
            g.int_tick <= 1'b0;
            if (edge_s)
            begin
                icnt_q <= (icnt_q + 5'h01 >= shalf) ? 5'h00 : icnt_q + 5'h01;
                g.int_tick <= (icnt_q + 5'h01 >= shalf);
            end
        end
    end

    // restarting the bit counter at each frame gives the short last pulse
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            fcnt_q <= 16'h0000;
            bcnt_q <= 16'h0000;
            g.bclk_m <= 1'b0;
            g.frame_m <= 1'b0;
        end
        else if (edge_s)
        begin
            if (fcnt_q + 16'h0001 >= flen)
            begin
                fcnt_q <= 16'h0000;
                bcnt_q <= 16'h0000;
                g.bclk_m <= 1'b0;
                g.frame_m <= 1'b1;
            end
            else
            begin
                fcnt_q <= fcnt_q + 16'h0001;
                g.frame_m <= (fcnt_q + 16'h0001) < (flen >> 1);
                if (bcnt_q + 16'h0001 >= bhalf || bhalf == 16'h0000)
                begin
                    bcnt_q <= 16'h0000;
                    g.bclk_m <= ~g.bclk_m;
                end
                else
                    bcnt_q <= bcnt_q + 16'h0001;
            end
        end
    end
endmodule

// ===== rtl/acc_compander.sv
// Purpose: G.711 style encoder for the ADC word and decoder for the DAC word
// Assumes: linear samples are 16-bit two's complement
// Notes: purely combinational
`timescale 1ns/1ns
module acc_compander
    import acc_pkg::*;
(
    acc_core_if.cmp c // samples, codes and modes
);
    function automatic logic [7:0] enc_mu(input logic [15:0] s);
        logic [12:0] mag;
        logic [12:0] b;
        logic [2:0] seg;
        mag = s[15] ? 13'(~s[14:2]) : s[14:2];
        b = (mag > 13'h1FDE) ? 13'h1FFF : mag + MU_BIAS;
        seg = 3'h0;
        for (int i = 5; i <= 12; i++)
            if (b[i])
                seg = 3'(i - 5);
        return ~{s[15], seg, 4'(b >> (seg + 3'h1))} ^ 8'h00;
    endfunction

    function automatic logic [7:0] enc_a(input logic [15:0] s);
        logic [11:0] mag;
        logic [2:0] seg;
        mag = s[15] ? 12'(~s[14:3]) : s[14:3];
        seg = 3'h0;
        for (int i = 5; i <= 11; i++)
            if (mag[i])
                seg = 3'(i - 4);
        return {~s[15], seg, 4'(mag >> ((seg == 3'h0) ? 3'h1 : seg))} ^ A_FLIP;
    endfunction

    function automatic logic [15:0] dec(input logic [7:0] code, input logic mu);
        logic [7:0] k;
        logic [15:0] m;
        k = mu ? ~code : code ^ A_FLIP;
        if (mu)
            m = ((16'(k[3:0]) << 3) + MU_DBIAS << k[6:4]) - MU_DBIAS;
        else if (k[6:4] == 3'h0)
            m = (16'(k[3:0]) << 4) + 16'h0008;
        else
            m = ((16'(k[3:0]) << 4) + A_DBIAS) << (k[6:4] - 3'h1);
        return (k[7] ^ ~mu) ? -m : m;
    endfunction

    assign c.adc_code = (c.adc_mode == ACC_CMP_MU) ? enc_mu(c.adc_lin) : enc_a(c.adc_lin);
    assign c.dac_lin = dec(c.dac_code, c.dac_mode == ACC_CMP_MU);
endmodule

// ===== rtl/acc_ctrl.sv
// Purpose: audio interface clocking, companding and pll control registers
// Assumes: Avalon-MM slave, pins sampled on sys_clk, analog pll outside
// Notes: byte address is four times the register index
`timescale 1ns/1ns
// Operation
// - master select set drives bit and frame clocks out, clear takes them in
// - bit clock divider codes 0..5 divide internal clock by 1 to 32
// - non-integer bit/frame ratio may give a short bit clock pulse
// - master clock scaler divides selected source by 1,1.5,2,3,4,6,8,12
// - clock source select picks external master clock or pll output
// - loopback feeds ADC serial output into DAC serial input
// - companding fields: off, reserved, mu-law, A-law
// - mu-law codes fully inverted, A-law codes even bits inverted
// - companded code sits in the eight top bits of the word
// - 13-bit mu-law or 12-bit A-law linear to 8-bit, eight segments
// - code holds sign bit 7, segment 6:4, mantissa 3:0
// - sample rate field selects 48 down to 8 kHz filter rates
// - pll enable bit turns the pll on or off
// - pll held off while reference impedance select is 00
// - fraction joins high 6, middle 9 and low 9 bits
// - prescale halves external master clock before the pll
// - shared pin function: select in, jack, temp, mute, pll clock, lock
// - shared pin functions beyond chip select only in two-wire mode; debounce clock for jack
// - in master mode the device paces both serial data lines
module acc_ctrl
    import acc_pkg::*;
(
    input wire logic sys_clk, // 25 MHz clock
    input wire logic rst, // async reset, high
    input wire logic [7:0] address, // byte address
    input wire logic read, // read request
    input wire logic write, // write request
    input wire logic [31:0] writedata, // write data
    output logic [31:0] readdata, // read data
    output logic waitrequest, // high until answer
    input wire logic mclk_i, // external master clock
    input wire logic pll_clk_i, // analog pll output
    input wire logic pll_lock_i, // pll lock level
    output logic pll_ref_o, // pll reference, maybe halved
    output logic pll_en_o, // pll power
    output logic [3:0] pll_int_o, // integer ratio
    output logic [23:0] pll_frac_o, // fraction ratio
    output logic [2:0] sample_rate_o, // filter rate select
    input wire logic bclk_i, // bit clock pin in
    output logic bclk_o, // bit clock pin out
    output logic bclk_oe, // bit clock drive
    input wire logic frame_i, // frame pin in
    output logic frame_o, // frame pin out
    output logic frame_oe, // frame drive
    output logic adc_dat_o, // serial ADC data
    input wire logic dac_dat_i, // serial DAC data
    input wire logic [15:0] adc_sample_i, // linear ADC sample
    input wire logic adc_valid_i, // sample strobe
    output logic [15:0] dac_sample_o, // linear DAC sample
    output logic dac_valid_o, // one-cycle strobe
    input wire logic two_wire_i, // control mode is two-wire
    input wire logic pin_i, // shared select pin in
    output logic pin_o, // shared select pin out
    output logic pin_oe, // shared select pin drive
    output logic chip_select_n_o, // select level to control port
    input wire logic temp_ok_i, // temperature ok
    input wire logic amute_i, // auto-mute active
    output logic jack_o, // jack insert state
    output logic debounce_clock_enable_o // slow clock enable
);
    logic [8:0] pwr1_q, afmt_q, cmp_q, clk_q, add_q, pin_q, pll_integer_ratio_q, frh_q, frm_q, frl_q;
    logic wait_q;
    logic [5:0] idx;
    logic hit;
    logic [8:0] rd_d;
    logic wr_go;
    logic ms, bit_clock_polarity, loop_en, pll_int_tog_q, mclk_q;
    logic [15:0] adc_hold_q, tx_q, rx_q;
    logic [4:0] bit_q;
    logic bclk_s_q, frame_s_q, bclk_n, frame_n, b_rise, b_fall, f_rise, ser_in;
    logic [1:0] adc_mode, dac_mode;
    logic [2:0] pin_fn;
    acc_core_if cif();

    assign ms = clk_q[F_MS];
    assign bit_clock_polarity = afmt_q[F_BCP];
    assign loop_en = cmp_q[F_LOOP];
    assign adc_mode = cmp_q[F_ADCC_LO +: 2];
    assign dac_mode = cmp_q[F_DACC_LO +: 2];
    assign pin_fn = pin_q[F_PIN_LO +: 3];
    assign idx = address[7:2];
    assign wr_go = write && !wait_q;

    assign cif.clk_src_sel = clk_q[F_CLOCK_SOURCE_SELECT];
    assign cif.scaler = clk_q[F_MDIV_LO +: 3];
    assign cif.bdiv = clk_q[F_BDIV_LO +: 3];
    assign cif.rate = add_q[F_SR_LO +: 3];
    assign cif.adc_lin = adc_hold_q;
    assign cif.adc_mode = adc_mode;
    assign cif.dac_mode = dac_mode;
    assign cif.dac_code = rx_q[15:8];

    acc_clkgen u_clkgen (
        .sys_clk(sys_clk),
        .rst(rst),
        .mclk_i(mclk_i),
        .pll_clk_i(pll_clk_i),
        .g(cif.gen)
    );

    acc_compander u_cmp (
        .c(cif.cmp)
    );

    always_comb
    begin
        hit = (address[1:0] == 2'b00);
        unique case (idx)
            IDX_PWR1: rd_d = pwr1_q;
            IDX_AFMT: rd_d = afmt_q;
            IDX_CMP: rd_d = cmp_q;
            IDX_CLK: rd_d = clk_q;
            IDX_ADD: rd_d = add_q;
            IDX_PIN: rd_d = pin_q;
            IDX_PLL_INTEGER_RATIO: rd_d = pll_integer_ratio_q;
            IDX_FRH: rd_d = frh_q;
            IDX_FRM: rd_d = frm_q;
            IDX_FRL: rd_d = frl_q;
            IDX_STAT: rd_d = {6'h00, jack_o, pll_en_o, pll_lock_i};
            default:
            begin
                rd_d = 9'h000;
                hit = 1'b0;
            end
        endcase
    end

    // one wait cycle for every access; unmapped reads give zero
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wait_q <= 1'b1;
            readdata <= 32'h0000_0000;
        end
        else
        begin
            wait_q <= !((read || write) && wait_q);
            if (read && wait_q)
                readdata <= hit ? {23'h000000, rd_d} : 32'h0000_0000;
        end
    end
    assign waitrequest = wait_q;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pwr1_q <= RST_PWR1;
            afmt_q <= RST_AFMT;
            cmp_q <= RST_CMP;
            clk_q <= RST_CLK;
            add_q <= RST_ADD;
            pin_q <= RST_PIN;
            pll_integer_ratio_q <= RST_PLL_INTEGER_RATIO;
            frh_q <= RST_FRH;
            frm_q <= RST_FRM;
            frl_q <= RST_FRL;
        end
        else if (wr_go && address[1:0] == 2'b00)
        begin
            unique case (idx)
                IDX_PWR1: pwr1_q <= writedata[8:0];
                IDX_AFMT: afmt_q <= writedata[8:0];
                IDX_CMP: cmp_q <= writedata[8:0];
                IDX_CLK: clk_q <= writedata[8:0];
                IDX_ADD: add_q <= writedata[8:0];
                IDX_PIN: pin_q <= writedata[8:0];
                IDX_PLL_INTEGER_RATIO: pll_integer_ratio_q <= writedata[8:0];
                IDX_FRH: frh_q <= writedata[8:0];
                IDX_FRM: frm_q <= writedata[8:0];
                IDX_FRL: frl_q <= writedata[8:0];
                default: ;
            endcase
        end
    end

    // pll, sample rate and debounce controls
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pll_en_o <= 1'b0;
            pll_int_o <= 4'h0;
            pll_frac_o <= 24'h000000;
            sample_rate_o <= 3'h0;
            debounce_clock_enable_o <= 1'b0;
            mclk_q <= 1'b0;
            pll_ref_o <= 1'b0;
        end
        else
        begin
            pll_en_o <= pwr1_q[F_PLL_ENABLE] && (pwr1_q[F_VMID_LO +: 2] != 2'b00);
            pll_int_o <= pll_integer_ratio_q[3:0];
            pll_frac_o <= {frh_q[5:0], frm_q, frl_q};
            sample_rate_o <= add_q[F_SR_LO +: 3];
            debounce_clock_enable_o <= add_q[F_DBCLK];
            mclk_q <= mclk_i;
            if (!pll_integer_ratio_q[F_PSC])
                pll_ref_o <= mclk_i;
            else if (mclk_i && !mclk_q)
                pll_ref_o <= ~pll_ref_o;
        end
    end

    // shared pin; functions beyond chip select need two-wire mode
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pin_o <= 1'b0;
            pin_oe <= 1'b0;
            chip_select_n_o <= 1'b1;
            jack_o <= 1'b0;
            pll_int_tog_q <= 1'b0;
        end
        else
        begin
            if (cif.int_tick)
                pll_int_tog_q <= ~pll_int_tog_q;
            chip_select_n_o <= two_wire_i ? 1'b1 : pin_i;
            if (two_wire_i && pin_fn == ACC_PIN_JACK && add_q[F_DBCLK])
                jack_o <= pin_i;
            pin_oe <= two_wire_i && pin_fn >= ACC_PIN_TEMP && pin_fn <= ACC_PIN_LOCK;
            unique case (pin_fn)
                ACC_PIN_TEMP: pin_o <= temp_ok_i;
                ACC_PIN_AMUTE: pin_o <= amute_i;
                ACC_PIN_PLLCLK: pin_o <= pll_int_tog_q;
                ACC_PIN_LOCK: pin_o <= pll_lock_i;
                default: pin_o <= 1'b0;
            endcase
        end
    end

    // master pins; polarity applied at the pin
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            bclk_o <= 1'b0;
            frame_o <= 1'b0;
            bclk_oe <= 1'b0;
            frame_oe <= 1'b0;
        end
        else
        begin
            bclk_oe <= ms;
            frame_oe <= ms;
            bclk_o <= cif.bclk_m ^ bit_clock_polarity;
            frame_o <= cif.frame_m;
        end
    end

    assign bclk_n = (ms ? cif.bclk_m : bclk_i ^ bit_clock_polarity);
    assign frame_n = ms ? cif.frame_m : frame_i;
    assign b_rise = bclk_n && !bclk_s_q;
    assign b_fall = !bclk_n && bclk_s_q;
    assign f_rise = frame_n && !frame_s_q;
    assign ser_in = loop_en ? adc_dat_o : dac_dat_i;

    // serial word: 16 bits MSB first from each frame start
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            bclk_s_q <= 1'b0;
            frame_s_q <= 1'b0;
            adc_hold_q <= 16'h0000;
            tx_q <= 16'h0000;
            rx_q <= 16'h0000;
            bit_q <= 5'h00;
            adc_dat_o <= 1'b0;
            dac_sample_o <= 16'h0000;
            dac_valid_o <= 1'b0;
        end
        else
        begin
            bclk_s_q <= bclk_n;
            frame_s_q <= frame_n;
            dac_valid_o <= 1'b0;
            if (adc_valid_i)
                adc_hold_q <= adc_sample_i;
            if (f_rise)
            begin
                bit_q <= 5'h00;
                tx_q <= adc_mode[1] ? {cif.adc_code, 8'h00} : adc_hold_q;
            end
            else if (b_fall && bit_q < 5'(WORD_W))
            begin
                adc_dat_o <= tx_q[15];
                tx_q <= {tx_q[14:0], 1'b0};
            end
            else if (b_rise && bit_q < 5'(WORD_W))
            begin
                rx_q <= {rx_q[14:0], ser_in};
                bit_q <= bit_q + 5'h01;
            end
            if (bit_q == 5'(WORD_W - 1) && b_rise)
                dac_valid_o <= 1'b1;
            if (dac_valid_o)
                dac_sample_o <= dac_mode[1] ? cif.dac_lin : rx_q;
        end
    end

    chk_bclk_dir: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(ms) |=> bclk_oe && frame_oe) else $error("master pins not driven");
    chk_slave_in: assert property (@(posedge sys_clk) disable iff (rst)
        !ms ##1 !ms |-> !bclk_oe) else $error("slave still drives bit clock");
    chk_pll_hold: assert property (@(posedge sys_clk) disable iff (rst)
        pwr1_q[F_VMID_LO +: 2] == 2'b00 |=> !pll_en_o) else $error("pll not held off");
    chk_pll_on: assert property (@(posedge sys_clk) disable iff (rst)
        pwr1_q[F_PLL_ENABLE] && pwr1_q[F_VMID_LO +: 2] != 2'b00 |=> pll_en_o)
        else $error("pll not on");
    chk_frac_join: assert property (@(posedge sys_clk) disable iff (rst)
        !$past(rst) |-> pll_frac_o[23:18] == $past(frh_q[5:0])
        && pll_frac_o[8:0] == $past(frl_q)) else $error("fraction misassembled");
    chk_code_top: assert property (@(posedge sys_clk) disable iff (rst)
        f_rise && adc_mode[1] |=> tx_q[7:0] == 8'h00) else $error("code not in top bits");
    chk_mu_zero: assert property (@(posedge sys_clk) disable iff (rst)
        adc_mode == ACC_CMP_MU && adc_hold_q == 16'h0000 |-> cif.adc_code == 8'hFF)
        else $error("mu-law zero code wrong");
    chk_a_zero: assert property (@(posedge sys_clk) disable iff (rst)
        adc_mode == ACC_CMP_A && adc_hold_q == 16'h0000 |-> cif.adc_code == 8'hD5)
        else $error("A-law zero code wrong");
    chk_mu_decode: assert property (@(posedge sys_clk) disable iff (rst)
        dac_mode == ACC_CMP_MU && rx_q[15:8] == 8'hFF |-> cif.dac_lin == 16'h0000)
        else $error("mu-law zero decode wrong");
    chk_pin_gate: assert property (@(posedge sys_clk) disable iff (rst)
        !two_wire_i |=> !pin_oe) else $error("shared pin driven in three-wire mode");
    chk_pin_lock: assert property (@(posedge sys_clk) disable iff (rst)
        two_wire_i && pin_fn == ACC_PIN_LOCK |=> pin_oe && pin_o == $past(pll_lock_i))
        else $error("lock not on shared pin");
endmodule

// ===== tb/acc_host_port.sv
// Purpose: host serial port model driving the slave clocks and DAC data
// Assumes: device is slave, bit clock is sys_clk/8
// Notes: 32 bit clocks per frame, frame high for the first one
`timescale 1ns/1ns
module acc_host_port (
    input wire logic sys_clk, // system clock
    input wire logic rst, // async reset
    output logic bclk, // bit clock to device
    output logic frame, // frame clock to device
    output logic dat // DAC serial data
);
    logic [7:0] cnt_q;
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            cnt_q <= 8'h00;
        else
            cnt_q <= cnt_q + 8'h01;
    end
    // frame rises with a bit clock rise, so the first fall carries the MSB
    assign bclk = ~cnt_q[2];
    assign frame = (cnt_q[7:3] == 5'h00);
    // changing pattern so a stale level never looks like data
    assign dat = cnt_q[3] ^ cnt_q[6];
endmodule

// ===== tb/testbench.sv
// Purpose: self-checking bench for the clock and companding control block
// Assumes: one wait cycle per register access, slave serial clocks from host model
// Notes: expected values worked out from the register map and G.711 codes
`timescale 1ns/1ns
module testbench;
    import acc_pkg::*;
    logic sys_clk = 0, rst = 1, read = 0, write = 0, adc_valid_i = 0, two_wire_i = 0;
    logic [7:0] address = 8'h00;
    logic [31:0] writedata = 32'h0, readdata, q;
    logic [15:0] adc_sample_i = 16'h0000, dac_sample_o;
    logic waitrequest, bclk_i, frame_i, dac_dat_i, pin_o, pin_oe, bclk_oe, frame_oe;
    logic pll_en_o, dac_valid_o, dbc_en;
    logic [3:0] pll_int_o;
    logic [23:0] pll_frac_o;
    logic [2:0] sample_rate_o;
    int errors = 0, n_checks = 0, cyc = 0;
    always #20 sys_clk = ~sys_clk;
    acc_host_port host (.sys_clk(sys_clk), .rst(rst), .bclk(bclk_i), .frame(frame_i),
        .dat(dac_dat_i));
    acc_ctrl dut (.sys_clk(sys_clk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .mclk_i(cyc[1]), .pll_clk_i(cyc[0]), .pll_lock_i(1'b1), .pll_ref_o(),
        .pll_en_o(pll_en_o), .pll_int_o(pll_int_o), .pll_frac_o(pll_frac_o),
        .sample_rate_o(sample_rate_o), .bclk_i(bclk_i), .bclk_o(), .bclk_oe(bclk_oe),
        .frame_i(frame_i), .frame_o(), .frame_oe(frame_oe), .adc_dat_o(),
        .dac_dat_i(dac_dat_i), .adc_sample_i(adc_sample_i), .adc_valid_i(adc_valid_i),
        .dac_sample_o(dac_sample_o), .dac_valid_o(dac_valid_o), .two_wire_i(two_wire_i),
        .pin_i(pin_oe ? pin_o : 1'b1), .pin_o(pin_o), .pin_oe(pin_oe),
        .chip_select_n_o(), .temp_ok_i(1'b0), .amute_i(1'b0), .jack_o(),
        .debounce_clock_enable_o(dbc_en));
    task stop_test;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errors++;
            stop_test;
        end
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e)
        begin
            $display("unexpected %s expected %h seen %h", n, e, s);
            errors++;
        end
    endtask
    // holds the request until waitrequest is sampled low
    task bus(input logic w, input logic [5:0] idx, input logic [8:0] d);
        @(posedge sys_clk);
        address <= {idx, 2'b00};
        writedata <= {23'h0, d};
        write <= w;
        read <= !w;
        do @(posedge sys_clk); while (waitrequest !== 1'b0);
        q = readdata;
        write <= 0;
        read <= 0;
        // registered outputs follow a new register value one edge later
        repeat (2) @(posedge sys_clk);
    endtask
    task test_regs;
        bus(0, IDX_CLK, 0); chk("clk reset", 32'h140, q);
        bus(0, IDX_PLL_INTEGER_RATIO, 0); chk("ratio reset", 32'h008, q);
        chk("ratio out", 32'h8, {28'h0, pll_int_o});
        bus(0, IDX_FRM, 0); chk("frac mid reset", 32'h093, q);
        bus(1, 6'h03, 9'h1FF); bus(0, 6'h03, 0); chk("unmapped", 32'h0, q);
        bus(1, IDX_FRH, 9'h03F); bus(1, IDX_FRM, 9'h1AB); bus(1, IDX_FRL, 9'h155);
        chk("fraction", 32'hFF5755, {8'h0, pll_frac_o});
        bus(1, IDX_PWR1, 9'h020); chk("pll held off", 32'h0, {31'h0, pll_en_o});
        bus(1, IDX_PWR1, 9'h021); chk("pll on", 32'h1, {31'h0, pll_en_o});
        bus(1, IDX_ADD, 9'h00B); chk("rate", 32'h5, {29'h0, sample_rate_o});
        chk("debounce", 32'h1, {31'h0, dbc_en});
        bus(1, IDX_CLK, 9'h141); chk("master", 32'h3, {30'h0, bclk_oe, frame_oe});
        bus(1, IDX_CLK, 9'h140); chk("slave", 32'h0, {30'h0, bclk_oe, frame_oe});
        two_wire_i <= 1;
        bus(1, IDX_PIN, 9'h004); chk("pin drive", 32'h1, {31'h0, pin_oe});
        bus(1, IDX_PIN, 9'h005); chk("pin lock", 32'h3, {30'h0, pin_oe, pin_o});
        $display("register test done");
    endtask
    // loopback with the given companding mode, checked after a settled frame
    task test_loop(input logic [8:0] mode, input logic [15:0] s, input logic [15:0] e);
        int k;
        bus(1, IDX_CMP, mode);
        adc_sample_i <= s;
        adc_valid_i <= 1;
        @(posedge sys_clk);
        adc_valid_i <= 0;
        repeat (2)
        begin
            k = 0;
            do @(posedge sys_clk); while (dac_valid_o !== 1'b1 && ++k < 600);
            chk("dac valid", 32'h1, {31'h0, dac_valid_o});
        end
        repeat (3) @(posedge sys_clk);
        chk("loop sample", {16'h0, e}, {16'h0, dac_sample_o});
        $display("loopback test done");
    endtask
    initial
    begin
        repeat (16) @(posedge sys_clk);
        rst <= 0;
        @(posedge sys_clk);
        test_regs;
        test_loop(9'h001, 16'hA5C3, 16'hA5C3);
        test_loop(9'h005, 16'h0000, 16'hFF00);
        test_loop(9'h007, 16'h0000, 16'hD500);
        test_loop(9'h015, 16'h0000, 16'h0000);
        test_loop(9'h01F, 16'h0000, 16'h0008);
        stop_test;
    end
endmodule
